// [rtl/slau_top.sv]
// Shift, rotate, nibble swap and bitwise logic unit of the core
`timescale 1ns/10ps
// Contract
// - Logical right shift, zero in, bit0 to carry
// - Right rotate through carry, old carry in
// - Logical left shift, zero in, bit7 to carry
// - Left rotate through carry, old carry in
// - Shifts also on memory byte, written back
// - Shifts change only the carry flag
// - Nibble swap exchanges working register halves
// - Nibble swap leaves all flags unchanged
// - AND working register with immediate
// - AND with memory, either destination
// - OR with immediate or memory
// - XOR with immediate or memory
// - Logic operations change only zero flag
// - Invert every working register bit
// - Invert memory byte, only zero flag changes
module slau_top (
  input  wire logic                        clk,                    // System clock, 100 MHz
  input  wire logic                        reset,                  // Synchronous reset, active high
  input  wire logic                        op_valid,               // One-cycle request strobe
  input  wire slau_pkg::slau_op_t          op,                     // Operation select
  input  wire logic                        src_imm,                // Second operand is the immediate
  input  wire logic                        dest_mem,               // Operate on and write the memory byte
  input  wire logic [slau_pkg::DATA_W-1:0] working_register_in,    // Current working register
  input  wire logic [slau_pkg::DATA_W-1:0] mem_rdata,              // Addressed memory byte
  input  wire logic [slau_pkg::DATA_W-1:0] imm,                    // Immediate operand
  input  wire logic [slau_pkg::FLAG_W-1:0] flags_in,               // Flags before the operation
  output logic                             done,                   // Answer strobe
  output logic                             refused,                // Request had an illegal form
  output logic                             working_register_we,    // Write working_register_out
  output logic [slau_pkg::DATA_W-1:0]      working_register_out,   // New working register value
  output logic                             mem_we,                 // Write mem_wdata to memory
  output logic [slau_pkg::DATA_W-1:0]      mem_wdata,              // New memory byte
  output logic [slau_pkg::FLAG_W-1:0]      flags_out               // Flags after the operation
);

  slau_flag_if fl ();                                    // Link to the flag logic

  logic [slau_pkg::DATA_W-1:0] src_byte;                 // Byte being shifted or inverted
  logic [slau_pkg::DATA_W-1:0] other_byte;               // Second operand of AND, OR, XOR
  logic [slau_pkg::DATA_W-1:0] result;                   // Combinational result
  logic                        carry_out;                // Bit leaving the byte
  logic                        carry_old;                // Carry before the operation
  logic                        is_binary;                // Operation uses a second operand
  logic                        bad_form;                 // Illegal combination of selects
  slau_pkg::slau_fclass_t      fclass;                   // Flag class of the operation

  logic                        done_q, done_d;           // Answer strobe
  logic                        refused_q, refused_d;     // Illegal form strobe
  logic                        acc_we_q, acc_we_d;       // Working register write strobe
  logic [slau_pkg::DATA_W-1:0] acc_q, acc_d;             // Working register value out
  logic                        mem_we_q, mem_we_d;       // Memory write strobe
  logic [slau_pkg::DATA_W-1:0] mem_q, mem_d;             // Memory byte out
  logic [slau_pkg::FLAG_W-1:0] flags_q, flags_d;         // Flags out

  logic [slau_pkg::DATA_W-1:0] chk_src_q;                // Check helper: shifted byte
  logic [slau_pkg::DATA_W-1:0] chk_oth_q;                // Check helper: second operand
  logic [slau_pkg::DATA_W-1:0] chk_acc_q;                // Check helper: working register
  logic [slau_pkg::FLAG_W-1:0] chk_flags_q;              // Check helper: flags before
  logic                        dest_mem_q;               // Check helper: destination of the last request

  // Operand steering and result computation
  always_comb begin
    carry_old  = flags_in[slau_pkg::FLAG_C];
    // Memory forms work on the memory byte, register forms on the working register
    src_byte   = dest_mem ? mem_rdata : working_register_in;
    other_byte = src_imm ? imm : mem_rdata;
    is_binary  = (op == slau_pkg::SLAU_AND_OP) || (op == slau_pkg::SLAU_OR_OP) ||
                 (op == slau_pkg::SLAU_XOR_OP);
    // An immediate cannot be a destination and the swap has no memory form
    bad_form   = (is_binary && src_imm && dest_mem) ||
                 (dest_mem && (op == slau_pkg::SLAU_NIBBLE_SWAP_OP));
    result     = src_byte;
    carry_out  = carry_old;
    fclass     = slau_pkg::SLAU_FLAGS_KEEP;
    case (op)
      slau_pkg::SLAU_SHIFT_RIGHT_LOGICAL_OP: begin
        result    = {1'b0, src_byte[7:1]};
        carry_out = src_byte[0];
        fclass    = slau_pkg::SLAU_FLAGS_CARRY;
      end
      slau_pkg::SLAU_ROTATE_RIGHT_CARRY_OP: begin
        result    = {carry_old, src_byte[7:1]};
        carry_out = src_byte[0];
        fclass    = slau_pkg::SLAU_FLAGS_CARRY;
      end
      slau_pkg::SLAU_SHIFT_LEFT_LOGICAL_OP: begin
        result    = {src_byte[6:0], 1'b0};
        carry_out = src_byte[7];
        fclass    = slau_pkg::SLAU_FLAGS_CARRY;
      end
      slau_pkg::SLAU_ROTATE_LEFT_CARRY_OP: begin
        result    = {src_byte[6:0], carry_old};
        carry_out = src_byte[7];
        fclass    = slau_pkg::SLAU_FLAGS_CARRY;
      end
      slau_pkg::SLAU_NIBBLE_SWAP_OP: begin
        // Halves trade places; no flag moves
        result = {working_register_in[slau_pkg::NIBBLE_W-1:0],
                  working_register_in[slau_pkg::DATA_W-1:slau_pkg::NIBBLE_W]};
        fclass = slau_pkg::SLAU_FLAGS_KEEP;
      end
      slau_pkg::SLAU_AND_OP: begin
        result = working_register_in & other_byte;
        fclass = slau_pkg::SLAU_FLAGS_ZERO;
      end
      slau_pkg::SLAU_OR_OP: begin
        result = working_register_in | other_byte;
        fclass = slau_pkg::SLAU_FLAGS_ZERO;
      end
      slau_pkg::SLAU_XOR_OP: begin
        result = working_register_in ^ other_byte;
        fclass = slau_pkg::SLAU_FLAGS_ZERO;
      end
      slau_pkg::SLAU_INVERT_OP: begin
        result = ~src_byte;
        fclass = slau_pkg::SLAU_FLAGS_ZERO;
      end
      default: begin
        result = src_byte;
        fclass = slau_pkg::SLAU_FLAGS_KEEP;
      end
    endcase
  end

  // Hand the result to the flag logic
  assign fl.flags_in  = flags_in;
  assign fl.fclass    = fclass;
  assign fl.result    = result;
  assign fl.carry_out = carry_out;

  slau_flags u_flags (
    .clk   (clk),
    .reset (reset),
    .fl    (fl.unit)
  );

  // Next values of the answer registers
  always_comb begin
    done_d    = 1'b0;
    refused_d = 1'b0;
    acc_we_d  = 1'b0;
    mem_we_d  = 1'b0;
    acc_d     = acc_q;
    mem_d     = mem_q;
    flags_d   = flags_q;
    if (op_valid && bad_form) begin
      // Nothing is written and flags pass through untouched
      done_d    = 1'b1;
      refused_d = 1'b1;
      acc_d     = working_register_in;
      flags_d   = flags_in;
    end else if (op_valid && dest_mem) begin
      // Memory form: only the byte is written back
      done_d   = 1'b1;
      mem_we_d = 1'b1;
      mem_d    = result;
      acc_d    = working_register_in;
      flags_d  = fl.flags_out;
    end else if (op_valid) begin
      // Register form: result lands in the working register
      done_d   = 1'b1;
      acc_we_d = 1'b1;
      acc_d    = result;
      flags_d  = fl.flags_out;
    end
  end

  // Answer registers; data holds between requests
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      acc_we_q  <= 1'b0;
      mem_we_q  <= 1'b0;
      acc_q     <= slau_pkg::RESULT_RST;
      mem_q     <= slau_pkg::RESULT_RST;
      flags_q   <= slau_pkg::FLAGS_RST;
    end else begin
      done_q    <= done_d;
      refused_q <= refused_d;
      acc_we_q  <= acc_we_d;
      mem_we_q  <= mem_we_d;
      acc_q     <= acc_d;
      mem_q     <= mem_d;
      flags_q   <= flags_d;
    end
  end

  assign done                 = done_q;
  assign refused              = refused_q;
  assign working_register_we  = acc_we_q;
  assign working_register_out = acc_q;
  assign mem_we               = mem_we_q;
  assign mem_wdata            = mem_q;
  assign flags_out            = flags_q;

  // Check helpers: operands as they were at the request
  always_ff @(posedge clk) begin
    chk_src_q   <= src_byte;
    chk_oth_q   <= other_byte;
    chk_acc_q   <= working_register_in;
    chk_flags_q <= flags_in;
    dest_mem_q  <= dest_mem;
  end

  // Result of a legal request in the selected destination
  sequence legal_req_s(slau_pkg::slau_op_t o);
    op_valid && !bad_form && op == o;
  endsequence

  shr_logic_a: assert property (@(posedge clk) disable iff (reset)
    legal_req_s(slau_pkg::SLAU_SHIFT_RIGHT_LOGICAL_OP) |=>
      (dest_mem_q ? mem_q : acc_q) == {1'b0, chk_src_q[7:1]} && flags_q[1] == chk_src_q[0])
    else $error("right shift result or carry wrong");

  rotr_carry_a: assert property (@(posedge clk) disable iff (reset)
    legal_req_s(slau_pkg::SLAU_ROTATE_RIGHT_CARRY_OP) |=>
      (dest_mem_q ? mem_q : acc_q) == {chk_flags_q[1], chk_src_q[7:1]} && flags_q[1] == chk_src_q[0])
    else $error("right rotate result or carry wrong");

  shl_logic_a: assert property (@(posedge clk) disable iff (reset)
    legal_req_s(slau_pkg::SLAU_SHIFT_LEFT_LOGICAL_OP) |=>
      (dest_mem_q ? mem_q : acc_q) == {chk_src_q[6:0], 1'b0} && flags_q[1] == chk_src_q[7])
    else $error("left shift result or carry wrong");

  rotl_carry_a: assert property (@(posedge clk) disable iff (reset)
    legal_req_s(slau_pkg::SLAU_ROTATE_LEFT_CARRY_OP) |=>
      (dest_mem_q ? mem_q : acc_q) == {chk_src_q[6:0], chk_flags_q[1]} && flags_q[1] == chk_src_q[7])
    else $error("left rotate result or carry wrong");

  swap_keep_a: assert property (@(posedge clk) disable iff (reset)
    legal_req_s(slau_pkg::SLAU_NIBBLE_SWAP_OP) |=>
      acc_we_q && acc_q == {chk_acc_q[3:0], chk_acc_q[7:4]} && flags_q == chk_flags_q)
    else $error("nibble swap wrong");

  logic_zero_a: assert property (@(posedge clk) disable iff (reset)
    op_valid && !bad_form && is_binary |=>
      flags_q[0] == ((dest_mem_q ? mem_q : acc_q) == 8'h00) && flags_q[3:1] == chk_flags_q[3:1])
    else $error("logic operation flags wrong");

  invert_res_a: assert property (@(posedge clk) disable iff (reset)
    legal_req_s(slau_pkg::SLAU_INVERT_OP) |=>
      (dest_mem_q ? mem_q : acc_q) == ~chk_src_q && flags_q[3:1] == chk_flags_q[3:1])
    else $error("invert result or flags wrong");

  mem_keeps_acc_a: assert property (@(posedge clk) disable iff (reset)
    op_valid && !bad_form && dest_mem |=> mem_we && !working_register_we && acc_q == chk_acc_q)
    else $error("memory form touched the working register");

  logic_ops_a: assert property (@(posedge clk) disable iff (reset)
    op_valid && !bad_form && is_binary |=>
      done_q && !refused_q && (acc_we_q != mem_we_q) && (mem_we_q == dest_mem_q))
    else $error("logic operation gave no single write");

  shift_mem_c: cover property (@(posedge clk) disable iff (reset)
    op_valid && dest_mem && op == slau_pkg::SLAU_ROTATE_LEFT_CARRY_OP ##1 mem_we);
  and_zero_c: cover property (@(posedge clk) disable iff (reset)
    op_valid && op == slau_pkg::SLAU_AND_OP ##1 flags_out[0]);
  refused_c: cover property (@(posedge clk) disable iff (reset) refused);
  back_to_back_c: cover property (@(posedge clk) disable iff (reset) done ##1 done);

endmodule : slau_top

// [rtl/slau_pkg.sv]
// Shared constants and types of the shift and logic unit
package slau_pkg;

  localparam int unsigned DATA_W     = 8;       // Operand and result width
  localparam int unsigned FLAG_W     = 4;       // Number of flags carried through the unit
  localparam int unsigned FLAG_Z     = 0;       // Zero flag position
  localparam int unsigned FLAG_C     = 1;       // Carry flag position
  localparam int unsigned FLAG_AC    = 2;       // Half carry flag position
  localparam int unsigned FLAG_OV    = 3;       // Signed range error flag position
  localparam int unsigned NIBBLE_W   = 4;       // Width of one nibble
  localparam logic [7:0]  RESULT_RST = 8'h00;   // Result registers after reset
  localparam logic [3:0]  FLAGS_RST  = 4'h0;    // Flag output after reset
  localparam int unsigned LATENCY    = 1;       // Cycles from request to answer

  // Operation select
  typedef enum logic [3:0] {
    SLAU_SHIFT_RIGHT_LOGICAL_OP,
    SLAU_ROTATE_RIGHT_CARRY_OP,
    SLAU_SHIFT_LEFT_LOGICAL_OP,
    SLAU_ROTATE_LEFT_CARRY_OP,
    SLAU_NIBBLE_SWAP_OP,
    SLAU_AND_OP,
    SLAU_OR_OP,
    SLAU_XOR_OP,
    SLAU_INVERT_OP
  } slau_op_t;

  // Which flag an operation touches
  typedef enum logic [1:0] {
    SLAU_FLAGS_KEEP,
    SLAU_FLAGS_CARRY,
    SLAU_FLAGS_ZERO
  } slau_fclass_t;

endpackage : slau_pkg

// [rtl/slau_flag_if.sv]
// Carrier between the datapath and its flag update logic
`timescale 1ns/10ps
interface slau_flag_if;
  logic [slau_pkg::FLAG_W-1:0] flags_in;   // Flags before the operation
  logic [slau_pkg::FLAG_W-1:0] flags_out;  // Flags after the operation
  slau_pkg::slau_fclass_t      fclass;     // Which flag may change
  logic [slau_pkg::DATA_W-1:0] result;     // Result byte of the operation
  logic                        carry_out;  // Bit shifted out

  modport core (output flags_in, output fclass, output result, output carry_out, input flags_out);
  modport unit (input flags_in, input fclass, input result, input carry_out, output flags_out);
endinterface : slau_flag_if

// [rtl/slau_flags.sv]
// Flag update logic of the shift and logic unit
`timescale 1ns/10ps
module slau_flags (
  input wire logic clk,     // Clock, used by the checks only
  input wire logic reset,   // Synchronous reset, used by the checks only
  slau_flag_if.unit fl      // Flags in, operation class, flags out
);

  // Only the flag named by the class moves; all others pass through
  always_comb begin
    fl.flags_out = fl.flags_in;
    case (fl.fclass)
      slau_pkg::SLAU_FLAGS_CARRY: begin
        fl.flags_out[slau_pkg::FLAG_C] = fl.carry_out;
      end
      slau_pkg::SLAU_FLAGS_ZERO: begin
        fl.flags_out[slau_pkg::FLAG_Z] = (fl.result == slau_pkg::RESULT_RST);
      end
      default: begin
        fl.flags_out = fl.flags_in;
      end
    endcase
  end

  // Shift class leaves zero, half carry and range error alone
  carry_only_a: assert property (@(posedge clk) disable iff (reset)
    fl.fclass == slau_pkg::SLAU_FLAGS_CARRY |->
      fl.flags_out[slau_pkg::FLAG_Z] == fl.flags_in[slau_pkg::FLAG_Z] &&
      fl.flags_out[slau_pkg::FLAG_AC] == fl.flags_in[slau_pkg::FLAG_AC] &&
      fl.flags_out[slau_pkg::FLAG_OV] == fl.flags_in[slau_pkg::FLAG_OV])
    else $error("shift changed a flag other than carry");

  // Logic class leaves carry, half carry and range error alone
  zero_only_a: assert property (@(posedge clk) disable iff (reset)
    fl.fclass == slau_pkg::SLAU_FLAGS_ZERO |->
      fl.flags_out[3:1] == fl.flags_in[3:1] &&
      fl.flags_out[slau_pkg::FLAG_Z] == (fl.result == 8'h00))
    else $error("logic operation flags wrong");

endmodule : slau_flags

// [verification/slau_mem_model.sv]
// Behavioural model of the decoder side: working register and one memory byte
`timescale 1ns/10ps
module slau_mem_model (
  input  wire logic       clk,      // System clock
  input  wire logic       reset,    // Synchronous reset
  input  wire logic       load,     // Preload both bytes from the bench
  input  wire logic [7:0] load_wr,  // Preload value of the working register
  input  wire logic [7:0] load_mem, // Preload value of the memory byte
  input  wire logic       wr_we,    // Working register write strobe from the unit
  input  wire logic [7:0] wr_new,   // New working register value
  input  wire logic       mem_we,   // Memory write strobe from the unit
  input  wire logic [7:0] mem_new,  // New memory byte
  output logic      [7:0] wr_q,     // Working register fed to the unit
  output logic      [7:0] mem_q     // Memory byte fed to the unit
);
  // Preload wins; the bench never preloads while the unit answers
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q  <= 8'h00;
      mem_q <= 8'h00;
    end else if (load) begin
      wr_q  <= load_wr;
      mem_q <= load_mem;
    end else begin
      // Write-back only on strobes, so a stray strobe shows as a wrong stored byte
      if (wr_we) begin
        wr_q <= wr_new;
      end
      if (mem_we) begin
        mem_q <= mem_new;
      end
    end
  end
endmodule : slau_mem_model

// [verification/slau_top_tb_top.sv]
// Self-checking testbench of the shift and logic unit
`timescale 1ns/10ps
module slau_top_tb_top;
  logic               clk;        // System clock
  logic               reset;      // Synchronous reset
  logic               op_valid;   // Request strobe
  slau_pkg::slau_op_t op;         // Operation select
  logic               src_imm;    // Immediate operand select
  logic               dest_mem;   // Memory form select
  logic [7:0]         imm;        // Immediate operand
  logic [3:0]         flags_in;   // Flags before the operation
  logic               load;       // Model preload strobe
  logic [7:0]         load_wr;    // Model preload, working register
  logic [7:0]         load_mem;   // Model preload, memory byte
  logic [7:0]         wr_val;     // Working register held by the model
  logic [7:0]         mem_val;    // Memory byte held by the model
  logic               done;       // Answer strobe
  logic               refused;    // Illegal form answer
  logic               wr_we;      // Working register write strobe
  logic               mem_we;     // Memory write strobe
  logic [7:0]         wr_out;     // New working register
  logic [7:0]         mem_wdata;  // New memory byte
  logic [3:0]         flags_out;  // Flags after the operation
  int                 err_total;  // Mismatches seen
  int                 n_compared; // Comparisons made

  slau_top u_slau_top (.clk(clk), .reset(reset), .op_valid(op_valid), .op(op), .src_imm(src_imm),
    .dest_mem(dest_mem), .working_register_in(wr_val), .mem_rdata(mem_val), .imm(imm), .flags_in(flags_in),
    .done(done), .refused(refused), .working_register_we(wr_we), .working_register_out(wr_out),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .flags_out(flags_out));

  slau_mem_model u_slau_mem_model (.clk(clk), .reset(reset), .load(load), .load_wr(load_wr),
    .load_mem(load_mem), .wr_we(wr_we), .wr_new(wr_out), .mem_we(mem_we), .mem_new(mem_wdata),
    .wr_q(wr_val), .mem_q(mem_val));

  // Clock generator, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare tasks, one per result width
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_flags

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Preload the model, issue one request and judge the answer and the write-back
  task automatic do_op(input slau_pkg::slau_op_t o, input logic si, input logic dm, input logic [7:0] wr,
                       input logic [7:0] mem, input logic [7:0] im, input logic [3:0] fl,
                       input logic [7:0] er, input logic [3:0] ef, input logic rf);
    int n;
    n = 0;
    @(posedge clk);
    load     <= 1'b1;
    load_wr  <= wr;
    load_mem <= mem;
    @(posedge clk);
    load     <= 1'b0;
    op_valid <= 1'b1;
    op       <= o;
    src_imm  <= si;
    dest_mem <= dm;
    imm      <= im;
    flags_in <= fl;
    @(posedge clk);
    op_valid <= 1'b0;
    // Answer is registered on the taking edge itself and seen at the next falling edge; the bound only guards a hang
    @(negedge clk);
    while (done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      err_total++;
      $display("mismatch at %0t: no answer", $time);
      stop_test();
    end
    cmp_bit(refused, rf, "refused");
    cmp_bit(wr_we, !rf && !dm, "register strobe");
    cmp_bit(mem_we, !rf && dm, "memory strobe");
    cmp_byte(wr_out, (rf || dm) ? wr : er, "working register");
    if (dm && !rf) cmp_byte(mem_wdata, er, "memory byte");
    cmp_flags(flags_out, rf ? fl : ef, "flags");
    @(negedge clk);
    cmp_bit(done, 1'b0, "done width");
    if (!rf) cmp_byte(dm ? mem_val : wr_val, er, "stored byte");
  endtask : do_op

  // Outputs right after reset release
  task automatic test_reset();
    @(negedge clk);
    cmp_bit(done, 1'b0, "reset done");
    cmp_byte(wr_out, 8'h00, "reset register");
    cmp_byte(mem_wdata, 8'h00, "reset memory");
    cmp_flags(flags_out, 4'h0, "reset flags");
    $display("test_reset done");
  endtask : test_reset

  // Register-form shifts and rotates, other flags all set on the right forms, all clear on the left shift, mixed on the left rotate, so a stray change shows
  task automatic test_shifts();
    do_op(slau_pkg::SLAU_SHIFT_RIGHT_LOGICAL_OP, 0, 0, 8'h81, 8'h00, 8'h00, 4'hd, 8'h40, 4'hf, 0);
    do_op(slau_pkg::SLAU_ROTATE_RIGHT_CARRY_OP, 0, 0, 8'h02, 8'h00, 8'h00, 4'hf, 8'h81, 4'hd, 0);
    do_op(slau_pkg::SLAU_SHIFT_LEFT_LOGICAL_OP, 0, 0, 8'h81, 8'h00, 8'h00, 4'h0, 8'h02, 4'h2, 0);
    do_op(slau_pkg::SLAU_ROTATE_LEFT_CARRY_OP, 0, 0, 8'h40, 8'h00, 8'h00, 4'hb, 8'h81, 4'h9, 0);
    $display("test_shifts done");
  endtask : test_shifts

  // Memory-form shifts; a zero result must not touch the zero flag
  task automatic test_mem_shifts();
    do_op(slau_pkg::SLAU_SHIFT_RIGHT_LOGICAL_OP, 0, 1, 8'h3c, 8'h01, 8'h00, 4'h4, 8'h00, 4'h6, 0);
    do_op(slau_pkg::SLAU_ROTATE_RIGHT_CARRY_OP, 0, 1, 8'h3c, 8'h00, 8'h00, 4'h2, 8'h80, 4'h0, 0);
    do_op(slau_pkg::SLAU_SHIFT_LEFT_LOGICAL_OP, 0, 1, 8'h3c, 8'h80, 8'h00, 4'h8, 8'h00, 4'ha, 0);
    do_op(slau_pkg::SLAU_ROTATE_LEFT_CARRY_OP, 0, 1, 8'h3c, 8'h7f, 8'h00, 4'h3, 8'hff, 4'h1, 0);
    $display("test_mem_shifts done");
  endtask : test_mem_shifts

  // Nibble swap, and its refused memory form
  task automatic test_swap();
    do_op(slau_pkg::SLAU_NIBBLE_SWAP_OP, 0, 0, 8'ha5, 8'h00, 8'h00, 4'h6, 8'h5a, 4'h6, 0);
    do_op(slau_pkg::SLAU_NIBBLE_SWAP_OP, 0, 1, 8'ha5, 8'h11, 8'h00, 4'h9, 8'ha5, 4'h9, 1);
    $display("test_swap done");
  endtask : test_swap

  // Bitwise logic in every source and destination form, zero and non-zero results
  task automatic test_logic();
    do_op(slau_pkg::SLAU_AND_OP, 1, 0, 8'hf0, 8'hff, 8'h0f, 4'he, 8'h00, 4'hf, 0);
    do_op(slau_pkg::SLAU_AND_OP, 0, 0, 8'hf3, 8'h3c, 8'hff, 4'h1, 8'h30, 4'h0, 0);
    do_op(slau_pkg::SLAU_AND_OP, 0, 1, 8'h0f, 8'hff, 8'h00, 4'ha, 8'h0f, 4'ha, 0);
    do_op(slau_pkg::SLAU_OR_OP, 1, 0, 8'h00, 8'hff, 8'h00, 4'h6, 8'h00, 4'h7, 0);
    do_op(slau_pkg::SLAU_OR_OP, 0, 1, 8'h50, 8'h05, 8'h00, 4'hf, 8'h55, 4'he, 0);
    do_op(slau_pkg::SLAU_XOR_OP, 1, 0, 8'hff, 8'h00, 8'hff, 4'h0, 8'h00, 4'h1, 0);
    do_op(slau_pkg::SLAU_XOR_OP, 0, 0, 8'h12, 8'h21, 8'h00, 4'h2, 8'h33, 4'h2, 0);
    do_op(slau_pkg::SLAU_XOR_OP, 0, 1, 8'h5a, 8'h0f, 8'h00, 4'hd, 8'h55, 4'hc, 0);
    do_op(slau_pkg::SLAU_OR_OP, 1, 1, 8'h11, 8'h22, 8'h33, 4'h5, 8'h11, 4'h5, 1);
    $display("test_logic done");
  endtask : test_logic

  // One's complement on both destinations
  task automatic test_invert();
    do_op(slau_pkg::SLAU_INVERT_OP, 0, 0, 8'h38, 8'h00, 8'h00, 4'he, 8'hc7, 4'he, 0);
    do_op(slau_pkg::SLAU_INVERT_OP, 0, 0, 8'hff, 8'h00, 8'h00, 4'h2, 8'h00, 4'h3, 0);
    do_op(slau_pkg::SLAU_INVERT_OP, 0, 1, 8'h77, 8'hff, 8'h00, 4'h6, 8'h00, 4'h7, 0);
    do_op(slau_pkg::SLAU_INVERT_OP, 0, 1, 8'h77, 8'h38, 8'h00, 4'h1, 8'hc7, 4'h0, 0);
    $display("test_invert done");
  endtask : test_invert

  // Main sequence: reset for two cycles, then every scenario
  initial begin
    err_total  = 0;
    n_compared = 0;
    reset      = 1'b1;
    op_valid   = 1'b0;
    op         = slau_pkg::SLAU_AND_OP;
    src_imm    = 1'b0;
    dest_mem   = 1'b0;
    imm        = 8'h00;
    flags_in   = 4'h0;
    load       = 1'b0;
    load_wr    = 8'h00;
    load_mem   = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_shifts();
    test_mem_shifts();
    test_swap();
    test_logic();
    test_invert();
    stop_test();
  end
endmodule : slau_top_tb_top
